/* verilog/fpc_ctrl.sv */
module fpc_ctrl #(
  parameter logic [31:0] KEY_FIRST = fpc_pkg::FPC_KEY_FIRST,
  parameter logic [31:0] KEY_SECOND = fpc_pkg::FPC_KEY_SECOND
) (
  input wire logic sys_clk_in, // System clock, 100 MHz
  input wire logic rst_in, // Power-on reset, async high
  input wire logic dev_rst_in, // Other device reset, sync pulse
  input wire logic [7:0] reg_addr_in, // Register byte address
  input wire logic [31:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [31:0] reg_rdata_out, // Read data, cycle after strobe
  input wire logic uv_sense_in, // Low supply comparator, async
  input wire logic [31:0] wp_boundary_in, // Protected below this
  input wire logic flash_done_in, // Array operation finished
  input wire logic flash_fail_in, // Array reports failure
  output logic flash_req_out, // One-cycle array request
  output logic [3:0] flash_op_out, // Requested operation code
  output logic [31:0] flash_addr_out, // Target address
  output logic [31:0] flash_wdata_out, // Word to program
  output logic [31:0] flash_src_out, // Row data source pointer
  output logic busy_out // Operation in flight
);
  import fpc_pkg::*;

  // Control register fields
  logic start_bit;
  logic program_enable;
  logic program_fail_flag;
  logic undervolt_error_flag;
  logic undervolt_active;
  logic [3:0] operation_code;
  // Data registers
  logic [31:0] target_addr;
  logic [31:0] program_word;
  logic [31:0] row_source_pointer;
  // Unlock tracking and synchroniser
  fpc_unlock_type unlock;
  logic uv_meta;
  logic uv_sync;
  // Decode and merge terms
  logic any_access;
  logic ctrl_hit;
  logic addr_hit;
  logic ctrl_wr;
  logic addr_wr;
  logic key_wr;
  logic data_wr;
  logic src_wr;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_eff;
  logic [31:0] addr_eff;
  logic accept;
  logic clear_start;
  logic [31:0] next_rdata;

  fpc_eng_if eng ();

  // Merge a write with current value per alias window
  function automatic logic [31:0] fpc_merge(
    input logic [1:0] kind,
    input logic [31:0] cur,
    input logic [31:0] wd
  );
    logic [31:0] res;
    res = wd;
    case (kind)
      FPC_ALIAS_CLR: res = cur & ~wd;
      FPC_ALIAS_SET: res = cur | wd;
      FPC_ALIAS_INV: res = cur ^ wd;
      default: res = wd;
    endcase
    return res;
  endfunction

  // Group decode: control and address carry set/clr/inv aliases
  assign any_access = reg_wr_in || reg_rd_in;
  assign ctrl_hit = reg_addr_in[7:4] == FPC_OFS_CTRL[7:4];
  assign addr_hit = reg_addr_in[7:4] == FPC_OFS_ADDR[7:4];
  assign ctrl_wr = reg_wr_in && ctrl_hit;
  assign addr_wr = reg_wr_in && addr_hit;
  assign key_wr = reg_wr_in && reg_addr_in == FPC_OFS_KEY;
  assign data_wr = reg_wr_in && reg_addr_in == FPC_OFS_DATA;
  assign src_wr = reg_wr_in && reg_addr_in == FPC_OFS_SRC;

  // Current control view; unused bits tie to zero
  always_comb begin
    ctrl_word = FPC_RST_WORD;
    ctrl_word[FPC_BIT_START] = start_bit;
    ctrl_word[FPC_BIT_EN] = program_enable;
    ctrl_word[FPC_BIT_FAIL] = program_fail_flag;
    ctrl_word[FPC_BIT_UVERR] = undervolt_error_flag;
    ctrl_word[FPC_BIT_UVACT] = undervolt_active;
    ctrl_word[3:0] = operation_code;
  end

  assign ctrl_eff = fpc_merge(reg_addr_in[3:2], ctrl_word, reg_wdata_in);
  assign addr_eff = fpc_merge(reg_addr_in[3:2], target_addr, reg_wdata_in);

  // Launch needs enable already set and an open unlock window
  // A device reset in the same cycle wins, so no launch slips through
  assign accept = ctrl_wr && ctrl_eff[FPC_BIT_START] && !start_bit
    && program_enable && unlock == FPC_OPEN && !dev_rst_in;
  assign clear_start = accept && operation_code == FPC_OP_NONE;

  // Unlock window: keys must be the two accesses just before start
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      unlock <= FPC_LOCKED;
    end else if (dev_rst_in) begin
      unlock <= FPC_LOCKED;
    end else if (any_access) begin
      if (key_wr && reg_wdata_in == KEY_FIRST) begin
        unlock <= FPC_HALF;
      end else if (key_wr && unlock == FPC_HALF
        && reg_wdata_in == KEY_SECOND) begin
        unlock <= FPC_OPEN;
      end else begin
        unlock <= FPC_LOCKED;
      end
    end
  end

  // Enable bit: the one field every device reset clears
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      program_enable <= 1'b0;
    end else if (dev_rst_in) begin
      program_enable <= 1'b0;
    end else if (clear_start) begin
      program_enable <= 1'b0;
    end else if (ctrl_wr) begin
      program_enable <= ctrl_eff[FPC_BIT_EN];
    end
  end

  // Start bit: set by an accepted launch, dropped on finish
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_bit <= 1'b0;
    end else if (accept) begin
      start_bit <= 1'b1;
    end else if (eng.finish) begin
      start_bit <= 1'b0;
    end
  end

  // Fail flag; a finish in the clear cycle still sets it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      program_fail_flag <= 1'b0;
    end else if (eng.finish && eng.fail) begin
      program_fail_flag <= 1'b1;
    end else if (clear_start) begin
      program_fail_flag <= 1'b0;
    end
  end

  // Supply sense crosses in from analog; two stages before use
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      uv_meta <= 1'b0;
      uv_sync <= 1'b0;
    end else begin
      uv_meta <= uv_sense_in;
      uv_sync <= uv_meta;
    end
  end

  // Detector powered only while enabled
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      undervolt_active <= 1'b0;
    end else begin
      undervolt_active <= program_enable && uv_sync;
    end
  end

  // Low supply during an operation marks possible corruption
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      undervolt_error_flag <= 1'b0;
    end else if (undervolt_active && start_bit) begin
      undervolt_error_flag <= 1'b1;
    end else if (clear_start) begin
      undervolt_error_flag <= 1'b0;
    end
  end

  // Code frozen while enabled so a launch cannot be retargeted
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      operation_code <= FPC_RST_OP;
    end else if (ctrl_wr && !program_enable) begin
      operation_code <= ctrl_eff[3:0];
    end
  end

  // Data registers survive every reset but power-on
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      target_addr <= FPC_RST_WORD;
      program_word <= FPC_RST_WORD;
      row_source_pointer <= FPC_RST_WORD;
    end else begin
      if (addr_wr) begin
        target_addr <= addr_eff;
      end
      if (data_wr) begin
        program_word <= reg_wdata_in;
      end
      if (src_wr) begin
        row_source_pointer <= reg_wdata_in;
      end
    end
  end

  // Read select; key and alias windows read as zero
  always_comb begin
    next_rdata = FPC_RST_WORD;
    if (reg_addr_in == FPC_OFS_CTRL) begin
      next_rdata = ctrl_word;
    end else if (reg_addr_in == FPC_OFS_KEY) begin
      next_rdata = FPC_RST_WORD;
    end else if (reg_addr_in == FPC_OFS_ADDR) begin
      next_rdata = target_addr;
    end else if (reg_addr_in == FPC_OFS_DATA) begin
      next_rdata = program_word;
    end else if (reg_addr_in == FPC_OFS_SRC) begin
      next_rdata = row_source_pointer;
    end else begin
      next_rdata = FPC_RST_WORD;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= FPC_RST_WORD;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= FPC_RST_WORD;
    end
  end

  // Engine hookup
  assign eng.start = accept;
  assign eng.opcode = operation_code;
  assign eng.addr = target_addr;

  fpc_op_engine u_engine (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .eng(eng),
    .wp_boundary_in(wp_boundary_in),
    .flash_done_in(flash_done_in),
    .flash_fail_in(flash_fail_in),
    .flash_req_out(flash_req_out),
    .flash_op_out(flash_op_out)
  );

  // Array side sees registered values
  assign flash_addr_out = target_addr;
  assign flash_wdata_out = program_word;
  assign flash_src_out = row_source_pointer;
  assign busy_out = start_bit;

  // Launch refused without enable and unlock
  start_refuse_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (ctrl_wr && ctrl_eff[FPC_BIT_START] && !start_bit
      && !(program_enable && unlock == FPC_OPEN)) |=> !start_bit
  ) else $error("start bit set without enable and unlock");

  // Accepted launch shows at once
  start_set_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    accept |=> start_bit && eng.busy
  ) else $error("accepted launch did not set start bit");

  // Finish drops the start bit
  start_clear_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    eng.finish |=> !start_bit && !eng.busy
  ) else $error("start bit not cleared on finish");

  // Detector dark while disabled
  uv_gated_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(program_enable) |-> !undervolt_active
  ) else $error("undervolt status while detector disabled");

  // Device reset clears the enable only
  dev_reset_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    dev_rst_in && program_fail_flag |=> !program_enable
      && program_fail_flag
  ) else $error("device reset handling of enable or flags wrong");

  // Failure reported in the flag
  fail_flag_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    eng.finish && eng.fail |=> program_fail_flag
  ) else $error("failed operation did not set fail flag");

  // Low supply during an operation latched
  uv_error_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    undervolt_active && start_bit |=> undervolt_error_flag
  ) else $error("undervolt error flag not set");

  // Status tracks the pin within three cycles
  uv_follow_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (uv_sense_in && program_enable)[*4] |-> undervolt_active
  ) else $error("undervolt status does not follow supply");

  // Code-0000 launch clears enable and flags
  noop_clear_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    clear_start |=> !program_enable && !program_fail_flag
      && !undervolt_error_flag
  ) else $error("code 0000 launch did not clear flags");

  // Code frozen while enabled
  op_lock_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    ctrl_wr && program_enable |=> $stable(operation_code)
  ) else $error("operation code changed while enabled");

  // Key register reads zero
  key_read_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == FPC_OFS_KEY |=> reg_rdata_out == 32'h0
  ) else $error("key register read nonzero");

  // Unused control bits read zero
  ctrl_unused_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == FPC_OFS_CTRL |=>
      reg_rdata_out[31:16] == 16'h0 && reg_rdata_out[10:4] == 7'h0
  ) else $error("unimplemented control bits read nonzero");

  // Any access in the open window closes it
  unlock_close_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    unlock == FPC_OPEN && any_access |=> unlock != FPC_OPEN
  ) else $error("unlock window survived an access");
endmodule // fpc_ctrl

/* inc/fpc_pkg.sv */
// Behaviour
// - Start accepted only when enabled and unlocked.
// - Start launches operation; hardware clears on finish.
// - Enable bit gates start and undervolt detector.
// - Device reset clears only the enable bit.
// - Fail flag set when operation fails.
// - Undervolt error flag set on low supply during an operation.
// - Undervolt status follows detector while enabled.
// - Flags clear on power-on or code-0000 start.
// - Operation code writable only while disabled.
// - Code 0001 programs word; others no-op/reserved.
// - Code 0011 programs unprotected row.
// - Code 0100 erases unprotected page.
// - Code 0101 erases array if unprotected.
// - Target address names page, row or word.
// - Unlock key register always reads zero.
// - Unused control bits read zero, ignore writes.
// - Program word register reset only at power-on.
// - Row data fetched from source pointer.
// - Page is 1 KB, row 128 bytes.
package fpc_pkg;
  // Register byte offsets; the control and address groups have set/clr/inv aliases
  localparam logic [7:0] FPC_OFS_CTRL = 8'h00;
  localparam logic [7:0] FPC_OFS_KEY = 8'h10;
  localparam logic [7:0] FPC_OFS_ADDR = 8'h20;
  localparam logic [7:0] FPC_OFS_DATA = 8'h30;
  localparam logic [7:0] FPC_OFS_SRC = 8'h40;
  // Alias selector in address bits 3:2
  localparam logic [1:0] FPC_ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] FPC_ALIAS_CLR = 2'h1;
  localparam logic [1:0] FPC_ALIAS_SET = 2'h2;
  localparam logic [1:0] FPC_ALIAS_INV = 2'h3;
  // Control register bit positions
  localparam int FPC_BIT_START = 15;
  localparam int FPC_BIT_EN = 14;
  localparam int FPC_BIT_FAIL = 13;
  localparam int FPC_BIT_UVERR = 12;
  localparam int FPC_BIT_UVACT = 11;
  // Operation codes
  localparam logic [3:0] FPC_OP_NONE = 4'h0;
  localparam logic [3:0] FPC_OP_WORD = 4'h1;
  localparam logic [3:0] FPC_OP_ROW = 4'h3;
  localparam logic [3:0] FPC_OP_PAGE = 4'h4;
  localparam logic [3:0] FPC_OP_CHIP = 4'h5;
  // Erase and program granules in bytes
  localparam logic [31:0] FPC_PAGE_BYTES = 32'h0000_0400;
  localparam logic [31:0] FPC_ROW_BYTES = 32'h0000_0080;
  // Reset values
  localparam logic [31:0] FPC_RST_WORD = 32'h0000_0000;
  localparam logic [3:0] FPC_RST_OP = 4'h0;
  // Default unlock keys, arbitrary values
  localparam logic [31:0] FPC_KEY_FIRST = 32'h5a5a_1234;
  localparam logic [31:0] FPC_KEY_SECOND = 32'ha5a5_8765;
  typedef enum logic [1:0] {
    FPC_LOCKED,
    FPC_HALF,
    FPC_OPEN
  } fpc_unlock_type;
  typedef enum logic [1:0] {
    FPC_ENG_IDLE,
    FPC_ENG_RUN,
    FPC_ENG_DONE
  } fpc_eng_type;
endpackage

/* inc/fpc_eng_if.sv */
// Launch and completion between register file and operation engine
interface fpc_eng_if;
  logic start;
  logic [3:0] opcode;
  logic [31:0] addr;
  logic busy;
  logic finish;
  logic fail;
  modport ctrl (output start, opcode, addr, input busy, finish, fail);
  modport engine (input start, opcode, addr, output busy, finish, fail);
endinterface

/* verilog/fpc_op_engine.sv */
module fpc_op_engine (
  input wire logic sys_clk_in, // System clock
  input wire logic rst_in, // Power-on reset, async high
  fpc_eng_if.engine eng, // Launch and completion
  input wire logic [31:0] wp_boundary_in, // Bytes below are protected
  input wire logic flash_done_in, // Array operation finished
  input wire logic flash_fail_in, // Array reports failure
  output logic flash_req_out, // One-cycle array request
  output logic [3:0] flash_op_out // Code of requested operation
);
  import fpc_pkg::*;
  fpc_eng_type state;
  logic blocked;
  logic real_op;
  logic fail;

  // Protection check on the granule the address names
  always_comb begin
    blocked = 1'b0;
    real_op = 1'b1;
    case (eng.opcode)
      FPC_OP_WORD: blocked = eng.addr < wp_boundary_in;
      FPC_OP_ROW: blocked = (eng.addr & ~(FPC_ROW_BYTES - 32'h1))
        < wp_boundary_in;
      FPC_OP_PAGE: blocked = (eng.addr & ~(FPC_PAGE_BYTES - 32'h1))
        < wp_boundary_in;
      FPC_OP_CHIP: blocked = wp_boundary_in != 32'h0;
      default: real_op = 1'b0;
    endcase
  end

  // Sequence: no-ops and protected targets finish without the array
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= FPC_ENG_IDLE;
      fail <= 1'b0;
      flash_req_out <= 1'b0;
      flash_op_out <= FPC_RST_OP;
    end else begin
      flash_req_out <= 1'b0;
      case (state)
        FPC_ENG_IDLE: begin
          if (eng.start) begin
            fail <= real_op && blocked;
            flash_op_out <= eng.opcode;
            if (real_op && !blocked) begin
              flash_req_out <= 1'b1;
              state <= FPC_ENG_RUN;
            end else begin
              state <= FPC_ENG_DONE;
            end
          end
        end
        FPC_ENG_RUN: begin
          if (flash_done_in) begin
            fail <= flash_fail_in;
            state <= FPC_ENG_DONE;
          end
        end
        default: state <= FPC_ENG_IDLE;
      endcase
    end
  end

  assign eng.busy = state != FPC_ENG_IDLE;
  assign eng.finish = state == FPC_ENG_DONE;
  assign eng.fail = fail;
endmodule // fpc_op_engine

/* verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fpc_pkg::*;

  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic dev_rst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic uv_sense_in = 1'b0;
  logic [31:0] wp_boundary_in = 32'h0000_1000;
  logic flash_done_in = 1'b0;
  logic flash_fail_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic flash_req_out;
  logic [3:0] flash_op_out;
  logic [31:0] flash_addr_out;
  logic [31:0] flash_wdata_out;
  logic [31:0] flash_src_out;
  logic busy_out;
  int n_errors = 0;
  int checked = 0;

  fpc_ctrl dut_u (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .dev_rst_in(dev_rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .uv_sense_in(uv_sense_in),
    .wp_boundary_in(wp_boundary_in),
    .flash_done_in(flash_done_in),
    .flash_fail_in(flash_fail_in),
    .flash_req_out(flash_req_out),
    .flash_op_out(flash_op_out),
    .flash_addr_out(flash_addr_out),
    .flash_wdata_out(flash_wdata_out),
    .flash_src_out(flash_src_out),
    .busy_out(busy_out)
  );

  // 100 MHz system clock
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One idle cycle between accesses keeps each strobe a clean pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask

  task automatic pulse_dev_rst();
    @(posedge sys_clk_in);
    dev_rst_in <= 1'b1;
    @(posedge sys_clk_in);
    dev_rst_in <= 1'b0;
  endtask

  // Full unlock and launch; array answers with fail status f
  task automatic run_op(input logic [3:0] op, input logic f,
                        input logic exp_req);
    logic seen;
    int i;
    seen = 1'b0;
    wr(FPC_OFS_CTRL, {28'h0, op});
    wr(FPC_OFS_CTRL, 32'h0000_4000 | {28'h0, op});
    wr(FPC_OFS_KEY, FPC_KEY_FIRST);
    wr(FPC_OFS_KEY, FPC_KEY_SECOND);
    wr(FPC_OFS_CTRL, 32'h0000_c000 | {28'h0, op});
    // Launch edge just passed; request pulse stands for this cycle only
    #1;
    chk({31'h0, busy_out}, 32'h1);
    for (i = 0; i < 4 && !seen; i++) begin
      if (flash_req_out === 1'b1) begin
        seen = 1'b1;
        chk({28'h0, flash_op_out}, {28'h0, op});
      end else begin
        @(posedge sys_clk_in);
        #1;
      end
    end
    chk({31'h0, seen}, {31'h0, exp_req});
    if (seen) begin
      @(posedge sys_clk_in);
      #1;
      chk({31'h0, flash_req_out}, 32'h0);
      @(posedge sys_clk_in);
      flash_done_in <= 1'b1;
      flash_fail_in <= f;
      @(posedge sys_clk_in);
      flash_done_in <= 1'b0;
      flash_fail_in <= 1'b0;
    end
    for (i = 0; i < 8 && busy_out !== 1'b0; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    if (busy_out !== 1'b0) begin
      n_errors++;
      give_verdict();
    end
  endtask

  // Reset values, aliases and unmapped places read zero
  task automatic s_reset_values();
    rd(FPC_OFS_CTRL, 32'h0);
    rd(FPC_OFS_KEY, 32'h0);
    rd(FPC_OFS_ADDR, 32'h0);
    rd(FPC_OFS_DATA, 32'h0);
    rd(FPC_OFS_SRC, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h80, 32'h0);
    rd(8'h04, 32'h0);
    // Set, clear and invert windows act on the stored value
    wr(8'h28, 32'h0000_00f0);
    wr(8'h24, 32'h0000_0030);
    rd(FPC_OFS_ADDR, 32'h0000_00c0);
    wr(8'h2c, 32'h0000_00c3);
    rd(FPC_OFS_ADDR, 32'h0000_0003);
    wr(8'h08, 32'h0000_0002);
    rd(FPC_OFS_CTRL, 32'h0000_0002);
  endtask

  // Reserved bits ignored; code frozen while enabled
  task automatic s_fields();
    wr(FPC_OFS_CTRL, 32'hffff_07f1);
    rd(FPC_OFS_CTRL, 32'h0000_0001);
    wr(FPC_OFS_CTRL, 32'h0000_4003);
    wr(FPC_OFS_CTRL, 32'h0000_4005);
    rd(FPC_OFS_CTRL, 32'h0000_4003);
    wr(FPC_OFS_KEY, 32'h1234_5678);
    rd(FPC_OFS_KEY, 32'h0);
  endtask

  // Start refused without keys, with a read between them
  task automatic s_refused_start();
    wr(FPC_OFS_CTRL, 32'h0000_c003);
    @(posedge sys_clk_in);
    #1;
    chk({31'h0, busy_out}, 32'h0);
    wr(FPC_OFS_KEY, FPC_KEY_FIRST);
    rd(FPC_OFS_CTRL, 32'h0000_4003);
    wr(FPC_OFS_KEY, FPC_KEY_SECOND);
    wr(FPC_OFS_CTRL, 32'h0000_c003);
    @(posedge sys_clk_in);
    #1;
    chk({31'h0, busy_out}, 32'h0);
    wr(FPC_OFS_CTRL, 32'h0000_0003);
    wr(FPC_OFS_KEY, FPC_KEY_FIRST);
    wr(FPC_OFS_KEY, FPC_KEY_SECOND);
    wr(FPC_OFS_CTRL, 32'h0000_8003);
    @(posedge sys_clk_in);
    #1;
    chk({31'h0, busy_out}, 32'h0);
  endtask

  // Word program, failing page erase, device reset, code-0000 clear
  task automatic s_program_erase();
    wr(FPC_OFS_ADDR, 32'h0000_2004);
    wr(FPC_OFS_DATA, 32'hdead_beef);
    rd(FPC_OFS_DATA, 32'hdead_beef);
    run_op(FPC_OP_WORD, 1'b0, 1'b1);
    chk(flash_addr_out, 32'h0000_2004);
    chk(flash_wdata_out, 32'hdead_beef);
    rd(FPC_OFS_CTRL, 32'h0000_4001);
    run_op(FPC_OP_PAGE, 1'b1, 1'b1);
    rd(FPC_OFS_CTRL, 32'h0000_6004);
    pulse_dev_rst();
    rd(FPC_OFS_CTRL, 32'h0000_2004);
    rd(FPC_OFS_DATA, 32'hdead_beef);
    run_op(FPC_OP_NONE, 1'b0, 1'b0);
    rd(FPC_OFS_CTRL, 32'h0000_0000);
  endtask

  // Protected targets fail without touching the array
  task automatic s_protected();
    wp_boundary_in <= 32'h0000_3000;
    run_op(FPC_OP_WORD, 1'b0, 1'b0);
    rd(FPC_OFS_CTRL, 32'h0000_6001);
    run_op(FPC_OP_NONE, 1'b0, 1'b0);
    run_op(FPC_OP_ROW, 1'b0, 1'b0);
    rd(FPC_OFS_CTRL, 32'h0000_6003);
    run_op(FPC_OP_NONE, 1'b0, 1'b0);
    wp_boundary_in <= 32'h0000_0001;
    run_op(FPC_OP_CHIP, 1'b0, 1'b0);
    rd(FPC_OFS_CTRL, 32'h0000_6005);
    run_op(FPC_OP_NONE, 1'b0, 1'b0);
    wp_boundary_in <= 32'h0000_0000;
    run_op(FPC_OP_CHIP, 1'b0, 1'b1);
    rd(FPC_OFS_CTRL, 32'h0000_4005);
  endtask

  // No-operation and reserved codes launch nothing
  task automatic s_noop_codes();
    logic [3:0] codes [4];
    int i;
    codes = '{4'h2, 4'h6, 4'h7, 4'hf};
    for (i = 0; i < 4; i++) begin
      run_op(codes[i], 1'b0, 1'b0);
      rd(FPC_OFS_CTRL, 32'h0000_4000 | {28'h0, codes[i]});
    end
  endtask

  // Row program under low supply; detector off when disabled
  task automatic s_undervolt();
    wr(FPC_OFS_SRC, 32'h0000_8000);
    #1;
    chk(flash_src_out, 32'h0000_8000);
    wr(FPC_OFS_ADDR, 32'h0000_2080);
    uv_sense_in <= 1'b1;
    run_op(FPC_OP_ROW, 1'b0, 1'b1);
    rd(FPC_OFS_CTRL, 32'h0000_5803);
    uv_sense_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    rd(FPC_OFS_CTRL, 32'h0000_5003);
    wr(FPC_OFS_CTRL, 32'h0000_0003);
    uv_sense_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    rd(FPC_OFS_CTRL, 32'h0000_1003);
    uv_sense_in <= 1'b0;
  endtask

  // Power-on reset clears flags and the program word
  task automatic s_power_on();
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(FPC_OFS_CTRL, 32'h0);
    rd(FPC_OFS_DATA, 32'h0);
  endtask

  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    s_reset_values();
    s_fields();
    s_refused_start();
    s_program_erase();
    s_protected();
    s_noop_codes();
    s_undervolt();
    s_power_on();
    give_verdict();
  end
endmodule // tb_top
